/* File: rtl/icd_diag.sv */
// Diagnostic CSR access path into a four-way instruction cache
// Functional notes
// - Array bit picks data or tag array
// - Index right-justified, unused upper bits zero
// - Tag access ignores chunk index bits
// - Access outside debug mode is illegal
// - 64-byte lines of 16 chunks
// - Two 16-bit halves, separate check fields
// - Four ways, four banks, index[5:4] bank
// - Index[3:2] picks chunk, ascending bytes
// - Data mode word holds instruction word
// - Tag right-justified, unused high bits zero
// - LRU bits shared by whole set
// - LRU bit meanings for pair/way choice
// - Word bit 0 mirrors line valid
// - Word/check registers hold location content
// - Diagnostic writes use software check bits
// - Select at 0x7C8, word at 0x7C9
// - Reserved bits zero, fields read legal
// - Trigger read loads, write-1 stores
// - Trigger bit reads zero always
// - Check register: two fields, tag low
`timescale 1ns/1ps
module icd_diag #(
    parameter int CACHE_KB = 16,
    parameter bit USE_ECC  = 1'b1
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // CSR request
    input  wire logic        csr_valid,
    input  wire logic        csr_write,
    input  wire logic [11:0] csr_addr,
    input  wire logic [31:0] csr_wdata,
    input  wire logic        debug_mode,
    // CSR answer
    output logic             csr_ready,
    output logic [31:0]      csr_rdata,
    output logic             csr_illegal
);
    import icd_pkg::*;

    localparam int IDX_W  = $clog2(CACHE_KB * 1024 / (ICD_WAYS * 4));
    localparam int SET_W  = IDX_W - 4;
    localparam int SETS   = 2 ** SET_W;
    localparam int TAG_W  = ICD_TAG_MAX_W - $clog2(CACHE_KB / ICD_MIN_KB);
    localparam int HCHK_W = USE_ECC ? ICD_ECC_W : 1;
    localparam int DAW    = ICD_WAY_W + IDX_W;
    localparam int TAW    = ICD_WAY_W + SET_W;
    localparam int DDW    = 32 + 2 * HCHK_W;
    localparam int TDW    = TAG_W + HCHK_W;

    ////////////////////////////////////////////////////////////////////////
    // Legal-value masks

    function automatic logic [31:0] sel_mask();
        logic [31:0] m;
        m = '0;
        m[ICD_SEL_ARRAY_BIT] = 1'b1;
        m[ICD_SEL_WAY_LSB +: ICD_WAY_W] = '1;
        m[ICD_SEL_IDX_LSB +: IDX_W] = '1;
        return m;
    endfunction

    function automatic logic [31:0] word_mask(input logic tag_mode);
        logic [31:0] m;
        m = '1;
        if (tag_mode)
        begin
            m = '0;
            m[ICD_TAG_LSB +: TAG_W] = '1;
            m[ICD_LRU_LSB +: ICD_LRU_W] = '1;
            m[ICD_VALID_BIT] = 1'b1;
        end
        return m;
    endfunction

    function automatic logic [9:0] chk_mask(input logic tag_mode);
        logic [9:0] m;
        m = '0;
        m[0 +: HCHK_W] = '1;
        if (!tag_mode)
        begin
            m[(USE_ECC ? ICD_CHK_HI_LSB : 1) +: HCHK_W] = '1;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and registers

    icd_state_t  state_r;
    logic [31:0] sel_r;
    logic [31:0] word_r;
    logic [9:0]  chk_r;
    logic [31:0] rdata_r;
    logic        illegal_r;
    logic        valid_r [ICD_WAYS * SETS];
    logic [2:0]  lru_r   [SETS];

    logic             tag_mode;
    logic [1:0]       way;
    logic [IDX_W-1:0] idx;
    logic [SET_W-1:0] set;
    logic [TAW-1:0]   vl_idx;
    logic             take;
    logic             hit;
    logic             legal;
    logic             go_rd;
    logic             go_wr;
    logic [31:0]      rd_val;
    logic [HCHK_W-1:0] chk_lo;
    logic [HCHK_W-1:0] chk_hi;

    icd_ram_if #(.AW(DAW), .DW(DDW)) dram ();
    icd_ram_if #(.AW(TAW), .DW(TDW)) tram ();

    // Location decode
    assign tag_mode = sel_r[ICD_SEL_ARRAY_BIT];
    assign way      = sel_r[ICD_SEL_WAY_LSB +: ICD_WAY_W];
    // Index[5:4] bank and [3:2] chunk form the low word address
    assign idx      = sel_r[ICD_SEL_IDX_LSB +: IDX_W];
    // Chunk bits dropped for tag and status
    assign set      = sel_r[ICD_IDX_SET_LSB +: SET_W];
    assign vl_idx   = {way, set};

    assign take  = (state_r == ICD_IDLE) && csr_valid;
    assign hit   = (csr_addr == ICD_ADDR_SELECT) || (csr_addr == ICD_ADDR_WORD)
                 || (csr_addr == ICD_ADDR_CHECK) || (csr_addr == ICD_ADDR_TRIG);
    assign legal = take && hit && debug_mode;
    assign go_rd = legal && !csr_write && (csr_addr == ICD_ADDR_TRIG);
    assign go_wr = legal && csr_write && (csr_addr == ICD_ADDR_TRIG)
                 && csr_wdata[ICD_TRIG_BIT];

    assign chk_lo = chk_r[0 +: HCHK_W];
    assign chk_hi = chk_r[(USE_ECC ? ICD_CHK_HI_LSB : 1) +: HCHK_W];

    ////////////////////////////////////////////////////////////////////////
    // Array ports: check bits are stored as software gave them

    assign dram.en    = (go_rd || go_wr) && !tag_mode;
    assign dram.we    = go_wr;
    assign dram.addr  = {way, idx};
    assign dram.wdata = {chk_hi, chk_lo, word_r};
    assign tram.en    = (go_rd || go_wr) && tag_mode;
    assign tram.we    = go_wr;
    assign tram.addr  = vl_idx;
    assign tram.wdata = {chk_lo, word_r[ICD_TAG_LSB +: TAG_W]};

    icd_ram #(.AW(DAW), .DW(DDW)) u_data (
        .clk  (clk),
        .port (dram)
    );

    icd_ram #(.AW(TAW), .DW(TDW)) u_tag (
        .clk  (clk),
        .port (tram)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: debug-mode reads of the trigger stall one cycle for the array

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ICD_IDLE;
        end
        else
        begin
            case (state_r)
                ICD_IDLE:    state_r <= take ? (go_rd ? ICD_RD_LOAD : ICD_RESP)
                                             : ICD_IDLE;
                ICD_RD_LOAD: state_r <= ICD_RESP;
                ICD_RESP:    state_r <= ICD_IDLE;
                default:     state_r <= ICD_IDLE;
            endcase
        end
    end

    assign csr_ready   = (state_r == ICD_RESP);
    assign csr_rdata   = rdata_r;
    assign csr_illegal = illegal_r;

    ////////////////////////////////////////////////////////////////////////
    // Selection register

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_r <= ICD_RESET_WORD;
        end
        else if (legal && csr_write && csr_addr == ICD_ADDR_SELECT)
        begin
            sel_r <= csr_wdata & sel_mask();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word and check registers

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            word_r <= ICD_RESET_WORD;
            chk_r  <= '0;
        end
        else if (state_r == ICD_RD_LOAD)
        begin
            if (tag_mode)
            begin
                word_r <= '0;
                word_r[ICD_TAG_LSB +: TAG_W] <= tram.rdata[0 +: TAG_W];
                word_r[ICD_LRU_LSB +: ICD_LRU_W] <= lru_r[set];
                word_r[ICD_VALID_BIT] <= valid_r[vl_idx];
                chk_r <= '0;
                chk_r[0 +: HCHK_W] <= tram.rdata[TAG_W +: HCHK_W];
            end
            else
            begin
                word_r <= dram.rdata[31:0];
                chk_r  <= '0;
                chk_r[0 +: HCHK_W] <= dram.rdata[32 +: HCHK_W];
                chk_r[(USE_ECC ? ICD_CHK_HI_LSB : 1) +: HCHK_W]
                    <= dram.rdata[32 + HCHK_W +: HCHK_W];
            end
        end
        else if (legal && csr_write && csr_addr == ICD_ADDR_WORD)
        begin
            word_r <= csr_wdata & word_mask(tag_mode);
        end
        else if (legal && csr_write && csr_addr == ICD_ADDR_CHECK)
        begin
            chk_r <= csr_wdata[ICD_CHK_W-1:0] & chk_mask(tag_mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flops: valid per line, pseudo-LRU per set
    // LRU bit 4 picks pair 0/1 or 2/3, bit 5 way 0/1, bit 6 way 2/3

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < ICD_WAYS * SETS; i++)
            begin
                valid_r[i] <= 1'b0;
            end
            for (int s = 0; s < SETS; s++)
            begin
                lru_r[s] <= '0;
            end
        end
        else if (go_wr && tag_mode)
        begin
            valid_r[vl_idx] <= word_r[ICD_VALID_BIT];
            lru_r[set] <= word_r[ICD_LRU_LSB +: ICD_LRU_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and illegal flag

    always_comb
    begin
        rd_val = '0;
        case (csr_addr)
            ICD_ADDR_SELECT: rd_val = sel_r;
            ICD_ADDR_WORD:   rd_val = word_r;
            ICD_ADDR_CHECK:  rd_val = {22'h00_0000, chk_r};
            default:         rd_val = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r   <= '0;
            illegal_r <= 1'b0;
        end
        else if (take)
        begin
            rdata_r   <= (legal && !csr_write) ? rd_val : '0;
            illegal_r <= hit && !debug_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_illegal_mach: assert property (@(posedge clk) disable iff (!rst_b)
        take && hit && !debug_mode |-> ##1 csr_illegal && csr_ready)
        else $error("machine mode access not flagged");

    chk_sel_nochange: assert property (@(posedge clk) disable iff (!rst_b)
        take && !debug_mode |=> $stable(sel_r) && $stable(word_r))
        else $error("register changed outside debug mode");

    chk_sel_reserved: assert property (@(posedge clk) disable iff (!rst_b)
        (sel_r & ~sel_mask()) == 32'h0000_0000)
        else $error("select reserved bits set");

    chk_trig_zero: assert property (@(posedge clk) disable iff (!rst_b)
        take && csr_addr == ICD_ADDR_TRIG && !csr_write ##2 csr_ready
        |-> csr_rdata == 32'h0000_0000)
        else $error("trigger read not zero");

    chk_read_stall: assert property (@(posedge clk) disable iff (!rst_b)
        go_rd |=> !csr_ready ##1 csr_ready)
        else $error("triggered read answered early");

    chk_plain_resp: assert property (@(posedge clk) disable iff (!rst_b)
        take && !go_rd |=> csr_ready)
        else $error("plain access not answered in one cycle");

    chk_valid_mirror: assert property (@(posedge clk) disable iff (!rst_b)
        go_wr && tag_mode ##3 (go_rd && tag_mode && $stable(sel_r))
        |=> ##1 word_r[ICD_VALID_BIT] == $past(word_r[ICD_VALID_BIT], 5))
        else $error("valid bit not returned");

    chk_tag_unused: assert property (@(posedge clk) disable iff (!rst_b)
        tag_mode && $past(state_r) == ICD_RD_LOAD
        |-> (word_r & ~word_mask(1'b1)) == 32'h0000_0000)
        else $error("unused tag word bits set after read");

    chk_chk_legal: assert property (@(posedge clk) disable iff (!rst_b)
        (chk_r & ~chk_mask(1'b0)) == 10'h000)
        else $error("check register illegal bits");

    cov_data_write: cover property (@(posedge clk) disable iff (!rst_b)
        go_wr && !tag_mode);
    cov_tag_read: cover property (@(posedge clk) disable iff (!rst_b)
        go_rd && tag_mode ##2 csr_ready);
    cov_illegal: cover property (@(posedge clk) disable iff (!rst_b)
        csr_illegal && csr_ready);

endmodule

/* File: rtl/icd_pkg.sv */
// Package with constants and types of the cache diagnostic access block
package icd_pkg;

    // CSR addresses
    localparam logic [11:0] ICD_ADDR_SELECT = 12'h07C8;
    localparam logic [11:0] ICD_ADDR_WORD   = 12'h07C9;
    localparam logic [11:0] ICD_ADDR_CHECK  = 12'h07CA;
    localparam logic [11:0] ICD_ADDR_TRIG   = 12'h07CB;

    // Selection register fields
    localparam int ICD_SEL_ARRAY_BIT = 24;
    localparam int ICD_SEL_WAY_LSB   = 20;
    localparam int ICD_SEL_IDX_LSB   = 2;
    localparam int ICD_SEL_IDX_MSB   = 15;

    // Index sub-fields
    localparam int ICD_IDX_CHUNK_LSB = 2;
    localparam int ICD_IDX_BANK_LSB  = 4;
    localparam int ICD_IDX_SET_LSB   = 6;

    // Word register fields in tag mode
    localparam int ICD_TAG_LSB   = 12;
    localparam int ICD_TAG_MAX_W = 20;
    localparam int ICD_LRU_LSB   = 4;
    localparam int ICD_LRU_W     = 3;
    localparam int ICD_VALID_BIT = 0;

    // Check register fields
    localparam int ICD_HALF_W    = 16;
    localparam int ICD_ECC_W     = 5;
    localparam int ICD_CHK_HI_LSB = 5;
    localparam int ICD_CHK_W     = 10;

    // Geometry
    localparam int ICD_WAYS       = 4;
    localparam int ICD_WAY_W      = 2;
    localparam int ICD_LINE_BYTES = 64;
    localparam int ICD_CHUNKS     = 16;
    localparam int ICD_MIN_KB     = 16;

    // Reset values and trigger bit
    localparam logic [31:0] ICD_RESET_WORD = 32'h0000_0000;
    localparam int          ICD_TRIG_BIT   = 0;

    typedef enum logic [1:0] {
        ICD_IDLE    = 2'b00,
        ICD_RD_LOAD = 2'b01,
        ICD_RESP    = 2'b10
    } icd_state_t;

endpackage

/* File: rtl/icd_ram_if.sv */
// Interface between the diagnostic block and one of its arrays
`timescale 1ns/1ps
interface icd_ram_if #(
    parameter int AW = 8,
    parameter int DW = 32
);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem  (input en, input we, input addr, input wdata,
                  output rdata);
endinterface

/* File: rtl/icd_ram.sv */
// Single-port array with registered read data
`timescale 1ns/1ps
module icd_ram #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock
    input wire logic clk,
    // Array port
    icd_ram_if.mem   port
);
    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk)
    begin
        if (port.en && port.we)
        begin
            mem_r[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (port.en && !port.we)
        begin
            port.rdata <= mem_r[port.addr];
        end
    end
endmodule

/* File: testbench/icache_diag_array_access_tb.sv */
// Self-checking bench for the cache diagnostic access block
`timescale 1ns/1ps
module icache_diag_array_access_tb;
    import icd_pkg::*;

    logic        clk;
    logic        rst_b;
    logic        csr_valid;
    logic        csr_write;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata;
    logic        debug_mode;
    logic        csr_ready;
    logic [31:0] csr_rdata;
    logic        csr_illegal;
    int          n_errors;
    int          n_checks;
    logic [31:0] rdat;
    logic        ill;
    int          lat;
    logic [31:0] sel;
    logic [31:0] csr_rdata_p;
    logic [31:0] rdat_p;

    ////////////////////////////////////////////////////////////////////////
    icd_diag #(
        .CACHE_KB (16),
        .USE_ECC  (1'b1)
    ) DUT (
        .clk         (clk),
        .rst_b       (rst_b),
        .csr_valid   (csr_valid),
        .csr_write   (csr_write),
        .csr_addr    (csr_addr),
        .csr_wdata   (csr_wdata),
        .debug_mode  (debug_mode),
        .csr_ready   (csr_ready),
        .csr_rdata   (csr_rdata),
        .csr_illegal (csr_illegal)
    );

    // Second build: parity check bits and a 32 KB cache
    icd_diag #(
        .CACHE_KB (32),
        .USE_ECC  (1'b0)
    ) DUT_PAR (
        .clk         (clk),
        .rst_b       (rst_b),
        .csr_valid   (csr_valid),
        .csr_write   (csr_write),
        .csr_addr    (csr_addr),
        .csr_wdata   (csr_wdata),
        .debug_mode  (debug_mode),
        .csr_ready   (),
        .csr_rdata   (csr_rdata_p),
        .csr_illegal ()
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One CSR access; answer sampled mid-cycle, request held to ready edge
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic dbg);
        int n;
        @(posedge clk);
        csr_valid  <= 1'b1;
        csr_write  <= w;
        csr_addr   <= a;
        csr_wdata  <= d;
        debug_mode <= dbg;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (csr_ready !== 1'b1 && n < 8);
        if (csr_ready !== 1'b1)
        begin
            n_errors++;
            stop_test();
        end
        lat  = n;
        rdat = csr_rdata;
        rdat_p = csr_rdata_p;
        ill  = csr_illegal;
        @(posedge clk);
        csr_valid <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 1'b1);
        chk("write illegal flag", {31'h0000_0000, ill}, 32'h0000_0000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000, 1'b1);
        chk($sformatf("read %h", a), rdat, exp);
    endtask

    function automatic logic [31:0] loc(input int i);
        return {8'h00, 2'b00, i[1:0], 14'h0030, i[3:0], 2'b00};
    endfunction

    function automatic logic [31:0] pat(input int i);
        return 32'h0F1E_2D3C + i * 32'h1111_1011;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors   = 0;
        n_checks   = 0;
        rst_b      = 1'b0;
        csr_valid  = 1'b0;
        csr_write  = 1'b0;
        csr_addr   = 12'h000;
        csr_wdata  = 32'h0000_0000;
        debug_mode = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values and answer latency
        for (int i = 0; i < 4; i++)
        begin
            rd(ICD_ADDR_SELECT + 12'(i), 32'h0000_0000);
            chk("latency", lat, (i == 3) ? 3 : 2);
        end
        // Selection field masking
        wr(ICD_ADDR_SELECT, 32'hFFFF_FFFF);
        rd(ICD_ADDR_SELECT, 32'h0130_0FFC);
        chk("select wide cache", rdat_p, 32'h0130_1FFC);
        // Access outside debug mode
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b0, ICD_ADDR_SELECT + 12'(i), 32'h0000_0000, 1'b0);
            chk("illegal flag", {31'h0000_0000, ill}, 32'h0000_0001);
            chk("illegal rdata", rdat, 32'h0000_0000);
        end
        acc(1'b1, ICD_ADDR_SELECT, 32'h0000_0000, 1'b0);
        rd(ICD_ADDR_SELECT, 32'h0130_0FFC);
        acc(1'b0, 12'h07CC, 32'h0000_0000, 1'b1);
        chk("unmapped illegal", {31'h0000_0000, ill}, 32'h0000_0000);
        chk("unmapped rdata", rdat, 32'h0000_0000);
        // Data array: eight locations over ways, banks and chunks
        wr(ICD_ADDR_SELECT, 32'h0000_0000);
        wr(ICD_ADDR_CHECK, 32'hFFFF_FFFF);
        rd(ICD_ADDR_CHECK, 32'h0000_03FF);
        chk("parity check mask", rdat_p, 32'h0000_0003);
        for (int i = 0; i < 8; i++)
        begin
            wr(ICD_ADDR_SELECT, loc(i));
            wr(ICD_ADDR_WORD, pat(i));
            wr(ICD_ADDR_CHECK, 32'h0000_03FF - 32'(i * 37));
            wr(ICD_ADDR_TRIG, 32'h0000_0001);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(ICD_ADDR_SELECT, loc(i));
            rd(ICD_ADDR_TRIG, 32'h0000_0000);
            rd(ICD_ADDR_WORD, pat(i));
            rd(ICD_ADDR_CHECK, 32'h0000_03FF - 32'(i * 37));
            chk("parity check", rdat_p,
                32'h0000_0003 & (32'h0000_03FF - 32'(i * 37)));
        end
        // Trigger write with bit zero clear stores nothing
        wr(ICD_ADDR_SELECT, loc(0));
        wr(ICD_ADDR_WORD, 32'hDEAD_BEEF);
        wr(ICD_ADDR_TRIG, 32'hFFFF_FFFE);
        rd(ICD_ADDR_TRIG, 32'h0000_0000);
        rd(ICD_ADDR_WORD, pat(0));
        // Tag array: field masking, shared LRU, chunk bits ignored
        sel = 32'h0120_00C0;
        wr(ICD_ADDR_SELECT, sel);
        wr(ICD_ADDR_WORD, 32'hFFFF_FFFF);
        rd(ICD_ADDR_WORD, 32'hFFFF_F071);
        chk("wide cache tag mask", rdat_p, 32'h7FFF_F071);
        wr(ICD_ADDR_CHECK, 32'hFFFF_FFFF);
        rd(ICD_ADDR_CHECK, 32'h0000_001F);
        chk("parity tag check", rdat_p, 32'h0000_0001);
        wr(ICD_ADDR_WORD, 32'hABCD_E031);
        wr(ICD_ADDR_CHECK, 32'h0000_000A);
        wr(ICD_ADDR_TRIG, 32'h0000_0001);
        rd(ICD_ADDR_TRIG, 32'h0000_0000);
        rd(ICD_ADDR_WORD, 32'hABCD_E031);
        wr(ICD_ADDR_SELECT, 32'h0100_00FC);
        wr(ICD_ADDR_WORD, 32'h1357_9050);
        wr(ICD_ADDR_CHECK, 32'h0000_0015);
        wr(ICD_ADDR_TRIG, 32'h0000_0001);
        wr(ICD_ADDR_SELECT, 32'h0120_00D4);
        rd(ICD_ADDR_TRIG, 32'h0000_0000);
        rd(ICD_ADDR_WORD, 32'hABCD_E051);
        chk("wide cache tag", rdat_p, 32'h2BCD_E051);
        rd(ICD_ADDR_CHECK, 32'h0000_000A);
        wr(ICD_ADDR_SELECT, 32'h0100_00C0);
        rd(ICD_ADDR_TRIG, 32'h0000_0000);
        rd(ICD_ADDR_WORD, 32'h1357_9050);
        rd(ICD_ADDR_CHECK, 32'h0000_0015);
        // Second reset clears the registers
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(ICD_ADDR_SELECT, 32'h0000_0000);
        rd(ICD_ADDR_WORD, 32'h0000_0000);
        stop_test();
    end
endmodule
